// File: rtl/host_port.sv
// Purpose: Host end of the expansion port
// Assumes: Card outputs arrive asynchronously to mclk
// Notes:   One cycle at a time; also the card's two-entry buffer
`timescale 1ns/1ps
`default_nettype none
`include "card_link_cfg.svh"

// ----------------------------------------
// Two-entry word buffer
// ----------------------------------------
module word_buffer #(
    parameter int W     = 16,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic         mclk,
    input  wire logic         rst_n,
    // Fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // Drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wptr_reg;
    logic [PW-1:0] rptr_reg;
    logic [CW-1:0] count_reg;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
        return (p == LAST) ? '0 : p + 1'b1;
    endfunction : bump

    assign in_ready  = (count_reg != FULL);
    assign out_valid = (count_reg != '0);
    assign out_data  = mem[rptr_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wptr_reg] <= in_data;
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wptr_reg  <= '0;
            rptr_reg  <= '0;
            count_reg <= '0;
        end
        else
        begin
            if (push)
                wptr_reg <= bump(wptr_reg);
            if (pop)
                rptr_reg <= bump(rptr_reg);
            count_reg <= count_reg + CW'(push) - CW'(pop);
        end
    end
endmodule : word_buffer

module host_port
    import card_link_pkg::*;
#(
    parameter int STB_CYC    = `STB_CYC,
    parameter int SAMPLE_CYC = `RDY_SAMPLE_CYC
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Connector
    card_link_if.host        link,
    // Command
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_addr,
    input  wire logic [15:0] cmd_wdata,
    input  wire logic        dma_read_en,
    // Answer
    output logic             resp_valid,
    output logic             resp_dma,
    output logic [15:0]      resp_rdata,
    output logic             irq_level
);
    localparam logic [4:0] SETUP_LAST  = 5'(`CS_SETUP_CYC - 1);
    localparam logic [4:0] STB_LAST    = 5'(STB_CYC - 1);
    localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYC - 1);
    localparam logic [4:0] HOLD_LAST   = 5'(`HOLD_CYC - 1);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [18:0] meta_reg;
    logic [18:0] sync_reg;
    logic        irq_s;
    logic        dreq_s;
    logic        ready_s;
    logic [15:0] data_s;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 19'h1ffff;
            sync_reg <= 19'h1ffff;
        end
        else
        begin
            meta_reg <= {link.irq, link.dreq, link.ready, link.peripheral_data_bus};
            sync_reg <= meta_reg;
        end
    end

    assign {irq_s, dreq_s, ready_s, data_s} = sync_reg;
    assign irq_level = irq_s;

    // ----------------------------------------
    // Cycle sequencer
    // ----------------------------------------
    host_state_e state_reg;
    logic [4:0]  cnt_reg;
    logic        dma_reg;
    logic        wr_reg;
    logic [7:0]  addr_reg;
    logic [15:0] wdata_reg;
    logic        start_dma;

    assign start_dma = dreq_s & dma_read_en;
    assign cmd_ready = (state_reg == H_IDLE) & ~start_dma;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg  <= H_IDLE;
            cnt_reg    <= 5'h00;
            dma_reg    <= 1'b0;
            wr_reg     <= 1'b0;
            addr_reg   <= 8'h00;
            wdata_reg  <= 16'h0000;
            resp_valid <= 1'b0;
            resp_dma   <= 1'b0;
            resp_rdata <= 16'h0000;
        end
        else
        begin
            resp_valid <= 1'b0;
            cnt_reg    <= cnt_reg + 5'h01;
            case (state_reg)
                H_IDLE:
                begin
                    cnt_reg <= 5'h00;
                    if (start_dma)
                    begin
                        dma_reg   <= 1'b1; // [R9]
                        wr_reg    <= 1'b0;
                        state_reg <= H_SETUP;
                    end
                    else if (cmd_valid)
                    begin
                        dma_reg   <= 1'b0;
                        wr_reg    <= cmd_write;
                        addr_reg  <= cmd_addr;
                        wdata_reg <= cmd_wdata;
                        state_reg <= H_SETUP;
                    end
                end
                H_SETUP:
                begin
                    if (cnt_reg == SETUP_LAST)
                    begin
                        cnt_reg   <= 5'h00;
                        state_reg <= H_STROBE; // [R1] [R11]
                    end
                end
                H_STROBE:
                begin
                    if ((cnt_reg == SAMPLE_LAST) & ~ready_s)
                        state_reg <= H_WAIT;
                    else if (cnt_reg == STB_LAST)
                    begin
                        cnt_reg    <= 5'h00;
                        resp_rdata <= data_s;
                        state_reg  <= H_HOLD; // [R3] [R12]
                    end
                end
                H_WAIT:
                begin
                    if (ready_s)
                    begin
                        cnt_reg    <= 5'h00;
                        resp_rdata <= data_s;
                        state_reg  <= H_HOLD; // [R6]
                    end
                end
                H_HOLD:
                begin
                    if ((cnt_reg >= HOLD_LAST) & ~(dma_reg & dreq_s))
                    begin
                        resp_valid <= ~wr_reg;
                        resp_dma   <= dma_reg;
                        state_reg  <= H_IDLE; // [R2] [R10] [R12]
                    end
                end
                default:
                    state_reg <= H_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    logic in_cycle;
    logic strobe;

    assign in_cycle = (state_reg != H_IDLE);
    assign strobe   = (state_reg == H_STROBE) | (state_reg == H_WAIT);

    assign link.cs_n            = ~(in_cycle & ~dma_reg);
    assign link.dack_n          = ~(in_cycle & dma_reg);
    assign link.rd_n            = ~(strobe & ~wr_reg);
    assign link.wr_n            = ~(strobe & wr_reg);
    assign link.latched_address = addr_reg;
    assign link.host_dout       = wdata_reg;
    assign link.host_doe        = in_cycle & wr_reg;
endmodule : host_port
`default_nettype wire

// File: rtl/card_link_cfg.svh
// Purpose: Timing counts and port addresses for the card link
// Assumes: mclk at 100 MHz on both ends
// Notes:   Counts derive from the printed times in ns
`ifndef CARD_LINK_CFG_SVH
`define CARD_LINK_CFG_SVH

`define CLK_NS            10
// Least times round up so no minimum is cut short
`define CEIL_CYC(ns)      (((ns) + `CLK_NS - 1) / `CLK_NS)

`define T_CS_STB_MIN_NS   10
`define T_STB_CS_MIN_NS   10

`define CS_SETUP_CYC      `CEIL_CYC(`T_CS_STB_MIN_NS)
`define HOLD_MIN_CYC      `CEIL_CYC(`T_STB_CS_MIN_NS)
`define HOLD_CYC          (`HOLD_MIN_CYC + 1)
`define STB_CYC           18
`define RDY_SAMPLE_CYC    12

// Card port map on the latched address
`define DATA_ADDR         8'h00
`define CTRL_ADDR         8'h01
`define STAT_RDV_BIT      0
`define STAT_SPC_BIT      1
`define STAT_IRQ_BIT      2

`endif

// File: rtl/card_link_pkg.sv
// Purpose: Types shared by both ends of the card link
// Assumes: Nothing
// Notes:   One-hot state codes
package card_link_pkg;
    typedef enum logic [3:0] {
        C_IDLE  = 4'h1,
        C_READ  = 4'h2,
        C_WRITE = 4'h4,
        C_DONE  = 4'h8
    } card_state_e;

    typedef enum logic [4:0] {
        H_IDLE   = 5'h01,
        H_SETUP  = 5'h02,
        H_STROBE = 5'h04,
        H_WAIT   = 5'h08,
        H_HOLD   = 5'h10
    } host_state_e;
endpackage : card_link_pkg

// File: rtl/card_link_if.sv
// Purpose: Connector between host and card
// Assumes: Data bus and ready line pulled high when undriven
// Notes:   Wire levels resolved here from the enables
`timescale 1ns/1ps
`default_nettype none
interface card_link_if;
    logic        cs_n;
    logic        rd_n;
    logic        wr_n;
    logic        dack_n;
    logic [7:0]  latched_address;
    logic [15:0] host_dout;
    logic        host_doe;
    logic [15:0] card_dout;
    logic        card_doe;
    logic        rdy_out;
    logic        rdy_oe;
    logic        irq;
    logic        dreq;
    logic [15:0] peripheral_data_bus;
    logic        ready;

    assign peripheral_data_bus = card_doe ? card_dout : (host_doe ? host_dout : 16'hffff);
    assign ready = rdy_oe ? rdy_out : 1'b1;

    modport host (
        output cs_n, rd_n, wr_n, dack_n, latched_address, host_dout, host_doe,
        input  irq, dreq, ready, peripheral_data_bus
    );
    modport card (
        input  cs_n, rd_n, wr_n, dack_n, latched_address, peripheral_data_bus, ready,
        output card_dout, card_doe, rdy_out, rdy_oe, irq, dreq
    );
endinterface : card_link_if
`default_nettype wire

// File: rtl/card_port.sv
// Purpose: Card end of the expansion port
// Assumes: Host strobes arrive asynchronously to mclk
// Notes:   Two-entry buffers on both data paths
// Behaviour
// R1 - Host asserts select 10 ns before strobe
// R2 - Strobe released 10 to 95 ns before select
// R3 - Unstretched strobe at most 255 ns
// R4 - Card pulls ready no sooner than 30 ns
// R5 - Ready must come early enough to count
// R6 - Host ends strobe 125 ns after ready
// R7 - Interrupt removed within 250 ns of clear
// R8 - Only the DMA variant uses DMA handshake
// R9 - Acknowledge within 100 ns of request
// R10 - Acknowledge released 10 ns after request drops
// R11 - Acknowledge 10 ns before strobe
// R12 - DMA strobe ends 10-95 ns early, max 255
// R13 - Interrupt level held, enable programmable
// R14 - Ready is open drain, active low
// R15 - Drive read data only during selected reads
`timescale 1ns/1ps
`default_nettype none
`include "card_link_cfg.svh"

// ----------------------------------------
// Card port
// ----------------------------------------
module card_port
    import card_link_pkg::*;
#(
    parameter logic DMA_VARIANT = 1'b1,
    parameter int   DEPTH       = 2
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // Connector
    card_link_if.card        link,
    // Words for the host to read
    input  wire logic [15:0] tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // Words the host wrote
    output logic [15:0]      rx_data,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    // Interrupt and DMA control
    input  wire logic        irq_event,
    input  wire logic        irq_enable,
    input  wire logic        dma_enable
);
    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    logic [27:0] pin_meta_reg;
    logic [27:0] pin_sync_reg;
    logic        cs_n_s;
    logic        rd_n_s;
    logic        wr_n_s;
    logic        dack_n_s;
    logic [7:0]  addr_s;
    logic [15:0] data_s;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_reg <= 28'hfffffff;
            pin_sync_reg <= 28'hfffffff;
        end
        else
        begin
            pin_meta_reg <= {link.cs_n, link.rd_n, link.wr_n, link.dack_n,
                             link.latched_address, link.peripheral_data_bus};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign {cs_n_s, rd_n_s, wr_n_s, dack_n_s, addr_s, data_s} = pin_sync_reg;

    // ----------------------------------------
    // Buffers
    // ----------------------------------------
    logic [15:0] txb_data;
    logic        txb_valid;
    logic        txb_pop;
    logic        rxb_ready;
    logic        rxb_push;

    word_buffer #(.W(16), .DEPTH(DEPTH)) u_tx_buf (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (txb_data),
        .out_valid (txb_valid),
        .out_ready (txb_pop)
    );

    word_buffer #(.W(16), .DEPTH(DEPTH)) u_rx_buf (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_data   (data_s),
        .in_valid  (rxb_push),
        .in_ready  (rxb_ready),
        .out_data  (rx_data),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    // ----------------------------------------
    // Cycle decode
    // ----------------------------------------
    card_state_e state_reg;
    card_state_e state_next;
    logic        dma_ok;
    logic        sel;
    logic        ack;
    logic        ctrl;
    logic        can_read;
    logic        can_write;
    logic        irq_clear;
    logic        pend_reg;
    logic [15:0] rdata_reg;
    logic        rd_loaded_reg;
    logic        rdy_oe_reg;
    logic        doe_reg;
    logic        irq_reg;
    logic        dreq_reg;

    assign dma_ok    = DMA_VARIANT & dma_enable; // [R8]
    assign sel       = ~cs_n_s;
    assign ack       = ~dack_n_s & dma_ok; // [R8]
    assign ctrl      = sel & (addr_s == `CTRL_ADDR);
    assign can_read  = ctrl | txb_valid;
    assign can_write = ctrl | rxb_ready;
    assign txb_pop   = (state_reg == C_READ) & ~ctrl & txb_valid;
    assign rxb_push  = (state_reg == C_WRITE) & ~ctrl & rxb_ready;
    assign irq_clear = (state_reg == C_WRITE) & ctrl;

    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            C_IDLE:
                if ((sel | ack) & ~rd_n_s)
                    state_next = C_READ;
                else if ((sel | ack) & ~wr_n_s)
                    state_next = C_WRITE;
            C_READ:
                if (can_read)
                    state_next = C_DONE;
            C_WRITE:
                if (can_write)
                    state_next = C_DONE;
            C_DONE:
                if (rd_n_s & wr_n_s)
                    state_next = C_IDLE;
            default:
                state_next = C_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            state_reg <= C_IDLE;
        else
            state_reg <= state_next;
    end

    // ----------------------------------------
    // Read data and bus drive
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_reg     <= 16'h0000;
            rd_loaded_reg <= 1'b0;
            doe_reg       <= 1'b0;
        end
        else
        begin
            if ((state_reg == C_READ) & can_read)
            begin
                rdata_reg <= ctrl ? {13'h0000, pend_reg, rxb_ready, txb_valid} : txb_data;
                rd_loaded_reg <= 1'b1;
            end
            else if (state_reg == C_IDLE)
                rd_loaded_reg <= 1'b0;
            // Driven only while the read is still seen, never into a write
            doe_reg <= (sel | ack) & ~rd_n_s & wr_n_s & rd_loaded_reg; // [R15]
        end
    end

    assign link.card_dout = rdata_reg;
    assign link.card_doe  = doe_reg;

    // ----------------------------------------
    // Ready stretch
    // ----------------------------------------
    // Two sync stages, the state flop and this flop put the pull four edges after the strobe,
    // early enough to be seen; a read holds it until its data drives the bus.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rdy_oe_reg <= 1'b0;
        else
            rdy_oe_reg <= ((state_reg == C_READ) & ~can_read) | ((state_reg == C_WRITE) & ~can_write) |
                          (rdy_oe_reg & ~rd_n_s & ~doe_reg); // [R4] [R5]
    end

    assign link.rdy_out = 1'b0; // [R14]
    assign link.rdy_oe  = rdy_oe_reg; // [R14]

    // ----------------------------------------
    // Interrupt
    // ----------------------------------------
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_reg <= 1'b0;
            irq_reg  <= 1'b0;
        end
        else
        begin
            // A new event beats a clear in the same cycle
            pend_reg <= irq_event | (pend_reg & ~irq_clear); // [R13]
            irq_reg  <= irq_enable & (irq_event | (pend_reg & ~irq_clear)); // [R7] [R13]
        end
    end

    assign link.irq = irq_reg;

    // ----------------------------------------
    // DMA request
    // ----------------------------------------
    // Request drops once the strobe is seen and returns only after the
    // acknowledge is released, so one request moves one word.
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            dreq_reg <= 1'b0;
        else if (state_reg != C_IDLE)
            dreq_reg <= 1'b0;
        else
            dreq_reg <= dma_ok & txb_valid & (dreq_reg | dack_n_s) & rd_n_s; // [R8]
    end

    assign link.dreq = dreq_reg;
endmodule : card_port
`default_nettype wire

// File: testbench/card_link_props.sv
// Purpose: Concurrent checks on the card link wires
// Assumes: One mclk domain, rst_n active low
// Notes:   Sits beside the link interface, no bind
`timescale 1ns/1ps
`default_nettype none
`include "card_link_cfg.svh"

module card_link_props (
    // Clock and reset
    input wire logic       mclk,
    input wire logic       rst_n,
    // Host drives
    input wire logic       cs_n,
    input wire logic       rd_n,
    input wire logic       wr_n,
    input wire logic       dack_n,
    input wire logic [7:0] latched_address,
    // Card drives
    input wire logic       card_doe,
    input wire logic       rdy_out,
    input wire logic       rdy_oe,
    input wire logic       ready,
    input wire logic       irq,
    input wire logic       dreq
);
    logic       stb_n;
    logic [4:0] stb_cnt_reg;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    assign stb_n = rd_n & wr_n;

    // Saturating count of cycles with a strobe low
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            stb_cnt_reg <= 5'h00;
        else if (stb_n)
            stb_cnt_reg <= 5'h00;
        else if (stb_cnt_reg != 5'h1f)
            stb_cnt_reg <= stb_cnt_reg + 5'h01;
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_cs_lead; $fell(stb_n) && dack_n |-> $past(!cs_n); endproperty
    a_cs_lead: assert property (p_cs_lead) else $error("strobe before select");
    property p_ack_lead; $fell(stb_n) && cs_n |-> $past(!dack_n); endproperty
    a_ack_lead: assert property (p_ack_lead) else $error("strobe before acknowledge");
    property p_cs_hold; $rose(stb_n) && !cs_n |=> !cs_n ##[0:8] cs_n; endproperty
    a_cs_hold: assert property (p_cs_hold) else $error("select hold out of range");
    property p_stb_width; $fell(stb_n) |-> ##[1:25] (stb_n || !ready); endproperty
    a_stb_width: assert property (p_stb_width) else $error("strobe too wide");
    property p_rdy_late; $fell(stb_n) |-> ready [*3]; endproperty
    a_rdy_late: assert property (p_rdy_late) else $error("ready pulled too soon");
    property p_rdy_early; $fell(ready) |-> stb_cnt_reg <= 5'd9; endproperty
    a_rdy_early: assert property (p_rdy_early) else $error("ready pulled too late");
    property p_irq_clr; $fell(wr_n) && !cs_n && latched_address == `CTRL_ADDR |-> ##[1:25] !irq; endproperty
    a_irq_clr: assert property (p_irq_clr) else $error("interrupt not removed");
    property p_dack; $rose(dreq) |-> ##[1:10] !dack_n; endproperty
    a_dack: assert property (p_dack) else $error("request not acknowledged");
    property p_rdy_od; rdy_oe |-> !rdy_out && !stb_n; endproperty
    a_rdy_od: assert property (p_rdy_od) else $error("ready driven wrongly");
    property p_doe_on; $rose(card_doe) |-> !rd_n && !(cs_n && dack_n); endproperty
    a_doe_on: assert property (p_doe_on) else $error("data driven outside read");
    property p_doe_off; $rose(rd_n) |-> ##[0:4] !card_doe; endproperty
    a_doe_off: assert property (p_doe_off) else $error("data bus not released");

    c_stretch: cover property ($fell(ready));
    c_dma: cover property ($fell(dack_n));
    c_irq_clr: cover property ($fell(irq));
endmodule : card_link_props
`default_nettype wire

// File: testbench/expansion_card_io_port_test.sv
// Purpose: Self-checking bench for host and card ends
// Assumes: Both ends on one 100 MHz mclk
// Notes:   Random words from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "card_link_cfg.svh"

`define CHECK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); end end

module expansion_card_io_port_test;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cmd_valid = 1'b0;
    logic        cmd_write = 1'b0;
    logic [7:0]  cmd_addr = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000;
    logic        dma_read_en = 1'b0;
    logic        cmd_ready, resp_valid, resp_dma, irq_level, tx_ready, rx_valid;
    logic [15:0] resp_rdata, rx_data;
    logic [15:0] tx_data = 16'h0000;
    logic        tx_valid = 1'b0;
    logic        rx_ready = 1'b0;
    logic        irq_event = 1'b0;
    logic        irq_enable = 1'b0;
    logic        dma_enable = 1'b0;
    int          err_total = 0;
    int          n_compared = 0;
    int          cycles = 0;
    integer      seed = 32'h6d9a;
    logic [15:0] w [3];

    card_link_if card_link_if_i ();

    card_port #(.DMA_VARIANT(1'b1), .DEPTH(2)) card_port_i (
        .mclk(mclk), .rst_n(rst_n), .link(card_link_if_i),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .irq_event(irq_event), .irq_enable(irq_enable), .dma_enable(dma_enable)
    );

    host_port host_port_i (
        .mclk(mclk), .rst_n(rst_n), .link(card_link_if_i),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .dma_read_en(dma_read_en), .resp_valid(resp_valid),
        .resp_dma(resp_dma), .resp_rdata(resp_rdata), .irq_level(irq_level)
    );

    card_link_props card_link_props_i (
        .mclk(mclk), .rst_n(rst_n), .cs_n(card_link_if_i.cs_n), .rd_n(card_link_if_i.rd_n),
        .wr_n(card_link_if_i.wr_n), .dack_n(card_link_if_i.dack_n),
        .latched_address(card_link_if_i.latched_address), .card_doe(card_link_if_i.card_doe),
        .rdy_out(card_link_if_i.rdy_out), .rdy_oe(card_link_if_i.rdy_oe),
        .ready(card_link_if_i.ready), .irq(card_link_if_i.irq), .dreq(card_link_if_i.dreq)
    );

    // ----------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------
    always #5 mclk = ~mclk;

    task automatic finish_test();
        if (err_total == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // A hung stall would otherwise run for ever
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            err_total++;
            finish_test();
        end
    end

    function automatic logic [15:0] exp_status(input logic pend, input logic space, input logic avail);
        exp_status = 16'h0000;
        exp_status[`STAT_IRQ_BIT] = pend;
        exp_status[`STAT_SPC_BIT] = space;
        exp_status[`STAT_RDV_BIT] = avail;
    endfunction : exp_status

    task automatic host_cmd(input logic wr, input logic [7:0] addr, input logic [15:0] data);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_write = wr;
        cmd_addr = addr;
        cmd_wdata = data;
        while (cmd_ready !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask : host_cmd

    task automatic wait_resp(input logic [15:0] exp, input logic dma);
        while (resp_valid !== 1'b1)
            @(negedge mclk);
        `CHECK("resp_rdata", exp, resp_rdata)
        `CHECK("resp_dma", dma, resp_dma)
    endtask : wait_resp

    task automatic read_chk(input logic [7:0] addr, input logic [15:0] exp);
        host_cmd(1'b0, addr, 16'h0000);
        wait_resp(exp, 1'b0);
    endtask : read_chk

    task automatic push_tx(input logic [15:0] data);
        @(negedge mclk);
        tx_valid = 1'b1;
        tx_data = data;
        while (tx_ready !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
        tx_valid = 1'b0;
    endtask : push_tx

    task automatic pop_rx(input logic [15:0] exp);
        @(negedge mclk);
        rx_ready = 1'b1;
        while (rx_valid !== 1'b1)
            @(negedge mclk);
        `CHECK("rx_data", exp, rx_data)
        @(negedge mclk);
        rx_ready = 1'b0;
    endtask : pop_rx

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        read_chk(`CTRL_ADDR, exp_status(1'b0, 1'b1, 1'b0));
        // Cause pending but masked, then unmasked, then cleared
        @(negedge mclk);
        irq_event = 1'b1;
        @(negedge mclk);
        irq_event = 1'b0;
        repeat (8) @(negedge mclk);
        `CHECK("irq_level", 1'b0, irq_level)
        read_chk(`CTRL_ADDR, exp_status(1'b1, 1'b1, 1'b0));
        irq_enable = 1'b1;
        repeat (40) @(negedge mclk);
        `CHECK("irq_level", 1'b1, irq_level)
        host_cmd(1'b1, `CTRL_ADDR, 16'h0000);
        repeat (25) @(negedge mclk);
        `CHECK("irq", 1'b0, card_link_if_i.irq)
        // Random traffic both ways
        for (int k = 0; k < 6; k++)
        begin
            w[0] = 16'($random(seed));
            host_cmd(1'b1, `DATA_ADDR, w[0]);
            pop_rx(w[0]);
            w[1] = 16'($random(seed));
            push_tx(w[1]);
            read_chk(`DATA_ADDR, w[1]);
        end
        // Receive buffer full: third write is stretched
        for (int k = 0; k < 3; k++)
            w[k] = 16'($random(seed));
        for (int k = 0; k < 3; k++)
            host_cmd(1'b1, `DATA_ADDR, w[k]);
        repeat (20) @(negedge mclk);
        `CHECK("ready", 1'b0, card_link_if_i.ready)
        for (int k = 0; k < 3; k++)
            pop_rx(w[k]);
        // Send buffer full, then back-to-back reads
        push_tx(w[0]);
        push_tx(w[1]);
        `CHECK("tx_ready", 1'b0, tx_ready)
        read_chk(`DATA_ADDR, w[0]);
        read_chk(`DATA_ADDR, w[1]);
        // Read on empty buffer waits on a stretched strobe
        fork
            read_chk(`DATA_ADDR, w[2]);
            begin
                repeat (40) @(negedge mclk);
                `CHECK("ready", 1'b0, card_link_if_i.ready)
                push_tx(w[2]);
            end
        join
        // No request while DMA is off, a read once it is on
        dma_read_en = 1'b1;
        push_tx(w[1]);
        repeat (30) @(negedge mclk);
        `CHECK("dreq", 1'b0, card_link_if_i.dreq)
        dma_enable = 1'b1;
        wait_resp(w[1], 1'b1);
        read_chk(`CTRL_ADDR, exp_status(1'b0, 1'b1, 1'b0));
        finish_test();
    end
endmodule : expansion_card_io_port_test
`default_nettype wire
